// ### dv/wwd_regs_tb_top.sv
`timescale 1ns/100ps

module wwd_regs_tb_top
    import wwd_pkg::*;
;
    // ----------------------------------------
    // Clock, ports, bookkeeping
    // ----------------------------------------
    localparam int SECONDARY_OSC_N = 4;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [2:0] addr_i = 3'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic [4:0] cfg_p = 5'h1F;
    logic [2:0] cfg_c = 3'h7;
    logic [2:0] cfg_w = 3'h7;
    logic [1:0] cfg_m = 2'h1;
    logic [2:0] osc = 3'h0;
    logic clr = 1'b0;
    logic wdt_reset_o, window_violation_o, wake_o, secondary_osc_restart_o, wdt_active_o;
    int n_errors = 0;
    int checks_done = 0;
    int rst_cnt = 0;
    int viol_cnt = 0;
    int rsc_cnt = 0;
    int wk_cnt = 0;
    logic slp = 1'b0;

    initial begin
        forever #10 clk_i = ~clk_i;
    end

    // Sleep is raised only around the wake test
    wwd_regs #(.SECONDARY_OSC_START(SECONDARY_OSC_N)) DUT (
        .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .cfg_period_field_i(cfg_p), .cfg_clock_field_i(cfg_c),
        .cfg_window_field_i(cfg_w), .cfg_operating_mode_i(cfg_m),
        .low_freq_osc_i(osc[0]), .mid_freq_osc_i(osc[1]), .secondary_osc_i(osc[2]),
        .sleep_i(slp), .clear_watchdog_instr_i(clr), .wdt_reset_o(wdt_reset_o),
        .window_violation_o(window_violation_o), .wake_o(wake_o),
        .secondary_osc_restart_o(secondary_osc_restart_o), .wdt_active_o(wdt_active_o)
    );

    always @(posedge clk_i) begin
        if (wdt_reset_o === 1'b1) rst_cnt <= rst_cnt + 1;
        if (window_violation_o === 1'b1) viol_cnt <= viol_cnt + 1;
        if (secondary_osc_restart_o === 1'b1) rsc_cnt <= rsc_cnt + 1;
        if (wake_o === 1'b1) wk_cnt <= wk_cnt + 1;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic do_reset(input logic [4:0] p, input logic [2:0] c, input logic [2:0] w,
                            input logic [1:0] m);
        @(posedge clk_i);
        rstn_i <= 1'b0;
        cfg_p <= p;
        cfg_c <= c;
        cfg_w <= w;
        cfg_m <= m;
        repeat (12) @(posedge clk_i);
        rstn_i <= 1'b1;
        // Writes are ignored until the straps have been loaded
        repeat (4) @(posedge clk_i);
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, exp);
    endtask

    // Osc pins kept well below clk/2 so the synchroniser sees every edge
    task automatic ticks(input int sel, input int n);
        repeat (n) begin
            @(posedge clk_i);
            osc[sel] <= 1'b1;
            repeat (4) @(posedge clk_i);
            osc[sel] <= 1'b0;
            repeat (3) @(posedge clk_i);
        end
        repeat (6) @(posedge clk_i);
    endtask

    task automatic clear_chk(input logic [7:0] ev, input logic [7:0] er);
        int r0;
        int v0;
        r0 = rst_cnt;
        v0 = viol_cnt;
        @(posedge clk_i);
        clr <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk(8'(viol_cnt - v0), ev);
        chk(8'(rst_cnt - r0), er);
    endtask

    task automatic active_chk(input logic e);
        repeat (4) @(posedge clk_i);
        #1;
        chk({7'h00, wdt_active_o}, {7'h00, e});
    endtask

    task automatic ev_chk(input int r0, input int e);
        chk(8'(rst_cnt - r0), 8'(e));
    endtask

    initial begin
        repeat (60000) @(posedge clk_i);
        n_errors++;
        $display("Error t=%0t got %h exp %h", $time, 8'h01, 8'h00);
        give_verdict();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        int r0;
        int v0;
        do_reset(5'h1F, 3'h7, 3'h7, 2'h1);
        rd(WWD_ADDR_CTRL0, 8'h16);
        rd(WWD_ADDR_CTRL1, 8'h07);
        rd(WWD_ADDR_PSL, 8'h00);
        rd(WWD_ADDR_PSH, 8'h00);
        rd(WWD_ADDR_TMR, 8'h04);
        rd(3'h5, 8'h00);
        wr(WWD_ADDR_PSL, 8'hFF);
        rd(WWD_ADDR_PSL, 8'h00);
        wr(WWD_ADDR_CTRL0, 8'hE5);
        rd(WWD_ADDR_CTRL0, 8'h25);
        for (int p = 0; p <= 18; p++) begin
            wr(WWD_ADDR_CTRL0, {2'b00, 5'(p), 1'b0});
            rd(WWD_ADDR_CTRL0, {2'b00, 5'(p), 1'b0});
        end
        for (int c = 0; c < 3; c++) begin
            for (int w = 0; w < 8; w++) begin
                wr(WWD_ADDR_CTRL1, {1'b1, 3'(c), 1'b1, 3'(w)});
                rd(WWD_ADDR_CTRL1, {1'b0, 3'(c), 1'b0, 3'(w)});
            end
        end
        $display("test reset_and_access done");

        wr(WWD_ADDR_CTRL1, 8'h07);
        wr(WWD_ADDR_CTRL0, 8'h06);
        ticks(0, 5);
        rd(WWD_ADDR_PSL, 8'h00);
        active_chk(1'b0);
        wr(WWD_ADDR_CTRL0, 8'h07);
        ticks(0, 21);
        rd(WWD_ADDR_PSL, 8'h05);
        rd(WWD_ADDR_PSH, 8'h00);
        rd(WWD_ADDR_TMR, 8'h10);
        active_chk(1'b1);
        $display("test prescale done");

        wr(WWD_ADDR_CTRL0, 8'h01);
        wr(WWD_ADDR_CTRL1, 8'h06);
        clear_chk(8'h01, 8'h01);
        rd(WWD_ADDR_CTRL0, 8'h01);
        rd(WWD_ADDR_TMR, 8'h04);
        ticks(0, 3);
        rd(WWD_ADDR_TMR, 8'h1C);
        clear_chk(8'h01, 8'h01);
        rd(WWD_ADDR_CTRL0, 8'h01);
        ticks(0, 4);
        rd(WWD_ADDR_TMR, 8'h24);
        clear_chk(8'h00, 8'h00);
        rd(WWD_ADDR_TMR, 8'h00);
        $display("test window done");

        do_reset(5'h05, 3'h2, 3'h3, 2'h3);
        rd(WWD_ADDR_CTRL0, 8'h0A);
        rd(WWD_ADDR_CTRL1, 8'h23);
        wr(WWD_ADDR_CTRL0, 8'hFF);
        wr(WWD_ADDR_CTRL1, 8'hFF);
        rd(WWD_ADDR_CTRL0, 8'h0B);
        rd(WWD_ADDR_CTRL1, 8'h23);
        $display("test locked done");

        for (int m = 0; m < 4; m++) begin
            do_reset(5'h1F, 3'h7, 3'h7, 2'(m));
            wr(WWD_ADDR_CTRL0, 8'h17);
            active_chk(m != 0);
            wr(WWD_ADDR_CTRL0, 8'h16);
            active_chk(m >= 2);
        end
        $display("test modes done");

        do_reset(5'h00, 3'h7, 3'h7, 2'h3);
        r0 = rst_cnt;
        ticks(0, 31);
        ev_chk(r0, 0);
        rd(WWD_ADDR_TMR, 8'hF8);
        v0 = viol_cnt;
        ticks(0, 1);
        ev_chk(r0, 1);
        chk(8'(viol_cnt - v0), 8'h00);
        rd(WWD_ADDR_TMR, 8'h00);
        clear_chk(8'h00, 8'h00);
        slp <= 1'b1;
        r0 = rst_cnt;
        ticks(0, 32);
        ev_chk(r0, 0);
        chk(8'(wk_cnt), 8'h01);
        slp <= 1'b0;
        wr(WWD_ADDR_CTRL1, 8'h17);
        r0 = rst_cnt;
        ticks(1, 31);
        ev_chk(r0, 0);
        ticks(1, 1);
        ev_chk(r0, 1);
        chk(8'(rsc_cnt), 8'h00);
        $display("test timeout done");

        wr(WWD_ADDR_CTRL1, 8'h27);
        r0 = rst_cnt;
        ticks(2, SECONDARY_OSC_N + 31);
        ev_chk(r0, 0);
        ticks(2, 1);
        ev_chk(r0, 1);
        chk(8'(rsc_cnt), 8'h01);
        ticks(2, SECONDARY_OSC_N + 31);
        ev_chk(r0, 1);
        ticks(2, 1);
        ev_chk(r0, 2);
        $display("test secondary_osc done");
        give_verdict();
    end
endmodule

// ### rtl/wwd_pkg.sv
package wwd_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [2:0] WWD_ADDR_CTRL0 = 3'h0;
    localparam logic [2:0] WWD_ADDR_CTRL1 = 3'h1;
    localparam logic [2:0] WWD_ADDR_PSL = 3'h2;
    localparam logic [2:0] WWD_ADDR_PSH = 3'h3;
    localparam logic [2:0] WWD_ADDR_TMR = 3'h4;

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int WWD_SEN_BIT = 0;
    localparam int WWD_PS_LSB = 1;
    localparam int WWD_PS_MSB = 5;
    localparam int WWD_WIN_LSB = 0;
    localparam int WWD_WIN_MSB = 2;
    localparam int WWD_CS_LSB = 4;
    localparam int WWD_CS_MSB = 6;
    localparam int WWD_ARM_BIT = 2;
    localparam int WWD_TMR_LSB = 3;
    localparam int WWD_TMR_MSB = 7;

    // ------------------------------------------------------------
    // Codes and reset values
    // ------------------------------------------------------------
    localparam logic [4:0] WWD_CFG_PS_FREE = 5'h1F;
    localparam logic [4:0] WWD_PS_DEFAULT = 5'h0B;
    localparam logic [4:0] WWD_PS_MAX = 5'h12;
    localparam logic [2:0] WWD_CFG_FREE3 = 3'h7;
    localparam logic [2:0] WWD_CS_LFO = 3'h0;
    localparam logic [2:0] WWD_CS_MFO = 3'h1;
    localparam logic [2:0] WWD_CS_SECONDARY_OSC = 3'h2;
    localparam logic [2:0] WWD_WIN_FULL = 3'h7;
    localparam logic [4:0] WWD_TMR_LAST = 5'h1F;
    localparam logic [1:0] WWD_MODE_OFF = 2'h0;
    localparam logic [1:0] WWD_MODE_SOFT = 2'h1;
    localparam logic [1:0] WWD_MODE_NOSLEEP = 2'h2;
    localparam logic [1:0] WWD_MODE_ON = 2'h3;
    localparam logic [1:0] WWD_LOAD_DONE = 2'h3;
    localparam logic [7:0] WWD_RD_ZERO = 8'h00;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    // Periods are nominal against the 31 kHz low-frequency oscillator
    localparam int WWD_LFO_HZ = 31000;
    localparam int WWD_SECONDARY_OSC_START_CNT = 1024;

endpackage

// ### rtl/wwd_regs.sv
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps

// Functional notes
// [R1] Period code doubles ratio from 1:32
// [R2] Period resets to 2s code or config
// [R3] Period locked unless config period all ones
// [R4] Soft enable only acts in mode 01
// [R5] Secondary oscillator restarts, waits 1024 counts
// [R6] Clock select picks low, mid, secondary
// [R7] Config clock 111 resets select to 000
// [R8] Clock select locked unless config 111
// [R9] Window code sets closed fraction
// [R10] Window select resets to config window
// [R11] Window select locked unless config 111
// [R12] 18-bit prescale readable in three places
// [R13] Firmware reads prescale only for debug
// [R14] Timer register shows 5-bit window value
// [R15] Armed flag reads in timer bit 2
// [R16] Unimplemented bits read zero
// [R17] Nominal periods reference 31 kHz oscillator
// [R18] Clear in closed window resets device
// [R19] Clear without arming read is violation; the code flags it only while window select is not 111
// [R20] Control writes, resets, clears zero count
// [R21] Window open from five count MSBs
// [R22] Count to ratio gives timeout reset
module wwd_regs
    import wwd_pkg::*;
#(
    parameter int PRE_W = 18,
    parameter int SECONDARY_OSC_START = WWD_SECONDARY_OSC_START_CNT
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic [4:0] cfg_period_field_i,
    input wire logic [2:0] cfg_clock_field_i,
    input wire logic [2:0] cfg_window_field_i,
    input wire logic [1:0] cfg_operating_mode_i,
    input wire logic low_freq_osc_i,
    input wire logic mid_freq_osc_i,
    input wire logic secondary_osc_i,
    input wire logic sleep_i,
    input wire logic clear_watchdog_instr_i,
    output logic wdt_reset_o,
    output logic window_violation_o,
    output logic wake_o,
    output logic secondary_osc_restart_o,
    output logic wdt_active_o
);

    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    logic [12:0] cfg_s1_r, cfg_s2_r;
    logic [3:0] pin_s1_r, pin_s2_r, pin_s3_r;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cfg_s1_r <= '0;
            cfg_s2_r <= '0;
        end else begin
            cfg_s1_r <= {cfg_operating_mode_i, cfg_window_field_i, cfg_clock_field_i,
                         cfg_period_field_i};
            cfg_s2_r <= cfg_s1_r;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            pin_s3_r <= '0;
        end else begin
            pin_s1_r <= {sleep_i, secondary_osc_i, mid_freq_osc_i, low_freq_osc_i};
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
        end
    end

    logic [4:0] cfg_ps;
    logic [2:0] cfg_cs, cfg_win;
    logic [1:0] cfg_mode;
    logic [3:0] pin_rise;
    logic sleep_s, sleep_enter;

    assign cfg_ps = cfg_s2_r[4:0];
    assign cfg_cs = cfg_s2_r[7:5];
    assign cfg_win = cfg_s2_r[10:8];
    assign cfg_mode = cfg_s2_r[12:11];
    assign pin_rise = pin_s2_r & ~pin_s3_r;
    assign sleep_s = pin_s2_r[3];
    assign sleep_enter = pin_rise[3];

    // ------------------------------------------------------------
    // Configuration capture
    // ------------------------------------------------------------
    // Config straps are caught after the synchronisers have filled
    logic [1:0] load_cnt_r;
    logic loaded, load_now;

    assign loaded = (load_cnt_r == WWD_LOAD_DONE);
    assign load_now = (load_cnt_r == WWD_LOAD_DONE - 2'h1);

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            load_cnt_r <= '0;
        end else if (!loaded) begin
            load_cnt_r <= load_cnt_r + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic [4:0] period_select_r;
    logic soft_enable_r;
    logic [2:0] clk_select_r, window_select_r;
    logic wr_ctrl0, wr_ctrl1, rd_ctrl0;

    assign wr_ctrl0 = wr_i && (addr_i == WWD_ADDR_CTRL0);
    assign wr_ctrl1 = wr_i && (addr_i == WWD_ADDR_CTRL1);
    assign rd_ctrl0 = rd_i && (addr_i == WWD_ADDR_CTRL0);

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            period_select_r <= WWD_PS_DEFAULT;
        // [R2] Period reset value
        end else if (load_now) begin
            period_select_r <= (cfg_ps == WWD_CFG_PS_FREE) ? WWD_PS_DEFAULT : cfg_ps;
        // [R3] Writable only when free
        end else if (wr_ctrl0 && loaded && cfg_ps == WWD_CFG_PS_FREE) begin
            period_select_r <= wdata_i[WWD_PS_MSB:WWD_PS_LSB];
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            soft_enable_r <= 1'b0;
        end else if (wr_ctrl0 && loaded) begin
            soft_enable_r <= wdata_i[WWD_SEN_BIT];
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            clk_select_r <= WWD_CS_LFO;
        // [R7] Free config clears select
        end else if (load_now) begin
            clk_select_r <= (cfg_cs == WWD_CFG_FREE3) ? WWD_CS_LFO : cfg_cs;
        // [R8] Locked unless free
        end else if (wr_ctrl1 && loaded && cfg_cs == WWD_CFG_FREE3) begin
            clk_select_r <= wdata_i[WWD_CS_MSB:WWD_CS_LSB];
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            window_select_r <= WWD_WIN_FULL;
        // [R10] Window from config
        end else if (load_now) begin
            window_select_r <= cfg_win;
        // [R11] Locked unless free
        end else if (wr_ctrl1 && loaded && cfg_win == WWD_CFG_FREE3) begin
            window_select_r <= wdata_i[WWD_WIN_MSB:WWD_WIN_LSB];
        end
    end

    // ------------------------------------------------------------
    // Clock source and secondary oscillator start-up
    // ------------------------------------------------------------
    logic [$clog2(SECONDARY_OSC_START+1)-1:0] secondary_osc_cnt_r;
    logic secondary_osc_ready, tick, wdt_on;

    assign secondary_osc_ready = (secondary_osc_cnt_r == ($clog2(SECONDARY_OSC_START+1))'(SECONDARY_OSC_START));

    // [R5] Start-up count after restart
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            secondary_osc_cnt_r <= '0;
        end else if (secondary_osc_restart_o) begin
            secondary_osc_cnt_r <= '0;
        end else if (pin_rise[2] && !secondary_osc_ready) begin
            secondary_osc_cnt_r <= secondary_osc_cnt_r + 1'b1;
        end
    end

    // [R6] Clock select decode
    always_comb begin
        unique case (clk_select_r)
            // [R17] Nominal low-freq reference
            WWD_CS_LFO: tick = pin_rise[0];
            WWD_CS_MFO: tick = pin_rise[1];
            // [R5] Held off until started
            WWD_CS_SECONDARY_OSC: tick = pin_rise[2] && secondary_osc_ready;
            default: tick = 1'b0;
        endcase
    end

    // [R4] Operating mode gate
    always_comb begin
        unique case (cfg_mode)
            WWD_MODE_ON: wdt_on = loaded;
            WWD_MODE_NOSLEEP: wdt_on = loaded && !sleep_s;
            WWD_MODE_SOFT: wdt_on = loaded && soft_enable_r;
            WWD_MODE_OFF: wdt_on = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Prescaler and window timer
    // ------------------------------------------------------------
    logic [PRE_W-1:0] pre_cnt_r, pre_mask;
    logic [4:0] win_tmr_r, ps_eff, win_bound;
    logic pre_last, timeout, win_open, windowed, armed_r, violation, clr_valid;

    // Unused high codes saturate at the longest period
    assign ps_eff = (period_select_r > WWD_PS_MAX) ? WWD_PS_MAX : period_select_r;
    // [R1] Ratio is 2 to the power ps plus five
    assign pre_mask = PRE_W'(({{PRE_W{1'b0}}, 1'b1} << ps_eff) - 1'b1);
    assign pre_last = (pre_cnt_r == pre_mask);
    // [R22] Timeout at the selected ratio
    assign timeout = wdt_on && tick && pre_last && (win_tmr_r == WWD_TMR_LAST);

    // [R9] Closed part is eighths of the period
    assign win_bound = {WWD_WIN_FULL - window_select_r, 2'b00};
    // [R21] Five count MSBs against boundary
    assign win_open = (win_tmr_r >= win_bound);
    assign windowed = (window_select_r != WWD_WIN_FULL);
    // [R18] Clear in closed window
    // [R19] Clear without arming
    assign violation = clear_watchdog_instr_i && wdt_on && windowed && (!armed_r || !win_open);
    assign clr_valid = clear_watchdog_instr_i && !violation;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pre_cnt_r <= '0;
            win_tmr_r <= '0;
        // [R20] Clearing conditions
        end else if (!wdt_on || clr_valid || wr_ctrl0 || wr_ctrl1 || sleep_enter
                     || violation || timeout) begin
            pre_cnt_r <= '0;
            win_tmr_r <= '0;
        end else if (tick) begin
            pre_cnt_r <= pre_last ? '0 : pre_cnt_r + 1'b1;
            if (pre_last) begin
                win_tmr_r <= win_tmr_r + 5'h01;
            end
        end
    end

    // Arming read wins over a clear in the same cycle
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            armed_r <= 1'b0;
        // [R19] Read arms the timer
        end else if (rd_ctrl0) begin
            armed_r <= 1'b1;
        end else if (clear_watchdog_instr_i || wr_ctrl0 || wr_ctrl1) begin
            armed_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Event outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wdt_reset_o <= 1'b0;
            window_violation_o <= 1'b0;
            wake_o <= 1'b0;
            secondary_osc_restart_o <= 1'b0;
            wdt_active_o <= 1'b0;
        end else begin
            // [R22] Timeout resets unless asleep
            wdt_reset_o <= (timeout && !sleep_s) || violation;
            // [R18] Violation flagged
            window_violation_o <= violation;
            wake_o <= timeout && sleep_s;
            // [R5] Oscillator restart on reset
            secondary_osc_restart_o <= ((timeout && !sleep_s) || violation)
                                       && (clk_select_r == WWD_CS_SECONDARY_OSC);
            wdt_active_o <= wdt_on;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Prescale bytes are not latched together: debug use only
    logic [7:0] rdata_nxt;

    always_comb begin
        rdata_nxt = WWD_RD_ZERO;
        unique case (addr_i)
            // [R16] Unimplemented bits zero
            WWD_ADDR_CTRL0: rdata_nxt = {2'b00, period_select_r, soft_enable_r};
            WWD_ADDR_CTRL1: rdata_nxt = {1'b0, clk_select_r, 1'b0, window_select_r};
            // [R12] Prescale count spread
            WWD_ADDR_PSL: rdata_nxt = pre_cnt_r[7:0];
            WWD_ADDR_PSH: rdata_nxt = pre_cnt_r[15:8];
            // [R14] Window value and armed flag
            // [R15] Armed status bit
            WWD_ADDR_TMR: rdata_nxt = {win_tmr_r, armed_r, pre_cnt_r[17:16]};
            default: rdata_nxt = WWD_RD_ZERO;
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_o <= WWD_RD_ZERO;
        end else if (rd_i) begin
            rdata_o <= rdata_nxt;
        end else begin
            rdata_o <= WWD_RD_ZERO;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    a_ps_reset_load: assert property (load_now |=> period_select_r == // [R2]
        (($past(cfg_ps) == WWD_CFG_PS_FREE) ? WWD_PS_DEFAULT : $past(cfg_ps)))
        else $error("period select reset value wrong");

    a_ps_locked: assert property (loaded && wr_ctrl0 && cfg_ps != WWD_CFG_PS_FREE // [R3]
        |=> $stable(period_select_r))
        else $error("locked period select changed");

    a_soft_mode: assert property (loaded && cfg_mode == WWD_MODE_SOFT // [R4]
        |-> wdt_on == soft_enable_r)
        else $error("soft enable not honoured");

    a_secondary_osc_hold: assert property (clk_select_r == WWD_CS_SECONDARY_OSC && !secondary_osc_ready // [R5]
        |-> !tick)
        else $error("secondary clock used before start-up");

    a_cs_reset: assert property (load_now && cfg_cs == WWD_CFG_FREE3 // [R7]
        |=> clk_select_r == WWD_CS_LFO)
        else $error("clock select reset wrong");

    a_cs_locked: assert property (loaded && wr_ctrl1 && cfg_cs != WWD_CFG_FREE3 // [R8]
        |=> $stable(clk_select_r))
        else $error("locked clock select changed");

    a_win_locked: assert property (loaded && wr_ctrl1 && cfg_win != WWD_CFG_FREE3 // [R11]
        |=> $stable(window_select_r))
        else $error("locked window select changed");

    a_rd_unimpl: assert property (rd_i && addr_i == WWD_ADDR_CTRL1 // [R16]
        |=> rdata_o[7] == 1'b0 && rdata_o[3] == 1'b0)
        else $error("unimplemented bits not zero");

    a_psl_view: assert property (rd_i && addr_i == WWD_ADDR_PSL // [R12]
        |=> rdata_o == $past(pre_cnt_r[7:0]))
        else $error("prescale low byte wrong");

    a_closed_clear: assert property (clear_watchdog_instr_i && wdt_on && windowed // [R18]
        && !win_open |=> wdt_reset_o && window_violation_o)
        else $error("closed window clear not reset");

    a_unarmed_clear: assert property (clear_watchdog_instr_i && wdt_on && windowed // [R19]
        && !armed_r |=> window_violation_o)
        else $error("unarmed clear not flagged");

    a_write_clears: assert property (wr_ctrl0 || wr_ctrl1 // [R20]
        |=> win_tmr_r == 5'h00 && pre_cnt_r == '0)
        else $error("control write did not clear count");

    a_timeout_rst: assert property (timeout && !sleep_s // [R22]
        |=> wdt_reset_o ##1 !wdt_reset_o)
        else $error("timeout reset missing");

    c_timeout: cover property (wdt_reset_o && !window_violation_o);
    c_violation: cover property (window_violation_o);
    c_good_clear: cover property (clr_valid && windowed && armed_r);
    c_sleep_wake: cover property (wake_o);

endmodule
